//--- lccr_regs.vh
`ifndef LCCR_REGS_VH
`define LCCR_REGS_VH

// -----------------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------------
`define LCCR_CMD_INT_RAMP 8'haa
`define LCCR_CMD_ALT_AC 8'hab

// -----------------------------------------------------------------------
// Integrator and ramp register fields
// -----------------------------------------------------------------------
`define LCCR_INT_GAIN_MSB 7
`define LCCR_INT_GAIN_LSB 6
`define LCCR_INT_TIME_MSB 5
`define LCCR_INT_TIME_LSB 3
`define LCCR_RAMP_MSB 2
`define LCCR_RAMP_LSB 0

// -----------------------------------------------------------------------
// Alternate AC compensation register fields
// -----------------------------------------------------------------------
`define LCCR_SPARE_GAIN_MSB 7
`define LCCR_SPARE_GAIN_LSB 4
`define LCCR_SPARE_LL_MSB 3
`define LCCR_SPARE_LL_LSB 0

// -----------------------------------------------------------------------
// Values held until the stored copy has been loaded
// -----------------------------------------------------------------------
`define LCCR_INT_RAMP_RST 8'h00
`define LCCR_ALT_AC_RST 8'h00

`endif

//--- lccr_onehot.v
`timescale 1ns/1ps
module lccr_onehot #(
    parameter SEL_W = 2
) (
    input wire [SEL_W-1:0] code,
    output wire [(1<<SEL_W)-1:0] sel
);

    // -------------------------------------------------------------------
    // One select line per field code
    // -------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < (1 << SEL_W); i = i + 1) begin : g_line
            assign sel[i] = ({{(32-SEL_W){1'b0}}, code} == i);
        end
    endgenerate

endmodule

//--- lccr_top.v
`timescale 1ns/1ps
// Function
// - Each register one fully read/write byte
// - Bits 7:6 drive integrator gain select
// - Bits 5:3 drive integrator time select
// - Bits 2:0 drive ramp amplitude select
// - Power-up value loaded from stored copy
// - Alternate register stored only, affects nothing
// - Bits 7:4 hold alternate AC gain code
// - Bits 3:0 hold alternate load-line code
`include "lccr_regs.vh"
module lccr_top (
    input wire core_clk,
    input wire rst,
    input wire nvm_valid,
    input wire [7:0] nvm_int_ramp,
    input wire [7:0] nvm_alt_ac,
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [7:0] cmd_wdata,
    output reg rsp_valid,
    output reg rsp_ack,
    output reg [7:0] rsp_rdata,
    output reg cfg_loaded,
    output reg [3:0] int_gain_sel,
    output reg [7:0] int_time_sel,
    output reg [7:0] ramp_sel
);

    // -------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------
    reg [7:0] int_ramp_r;
    reg [7:0] int_ramp_nxt;
    reg [7:0] alt_ac_r;
    reg [7:0] alt_ac_nxt;
    reg load_pend_r;
    wire hit_int;
    wire hit_alt;
    wire do_load;
    wire [3:0] gain_dec;
    wire [7:0] time_dec;
    wire [7:0] ramp_dec;

    assign hit_int = (cmd_code == `LCCR_CMD_INT_RAMP);
    assign hit_alt = (cmd_code == `LCCR_CMD_ALT_AC);
    assign do_load = load_pend_r & nvm_valid;

    // -------------------------------------------------------------------
    // Next values: stored copy first, then a host write on top of it
    // -------------------------------------------------------------------
    always @* begin
        int_ramp_nxt = int_ramp_r;
        alt_ac_nxt = alt_ac_r;
        if (do_load) begin
            int_ramp_nxt = nvm_int_ramp;
            alt_ac_nxt = nvm_alt_ac;
        end
        if (cmd_valid && cmd_write && hit_int) begin
            int_ramp_nxt = cmd_wdata;
        end
        // Whole byte kept, reserved gain codes included
        if (cmd_valid && cmd_write && hit_alt) begin
            alt_ac_nxt = cmd_wdata;
        end
    end

    // -------------------------------------------------------------------
    // Decoders for the loop selects
    // -------------------------------------------------------------------
    lccr_onehot #(.SEL_W(2)) u_gain (
        .code(int_ramp_nxt[`LCCR_INT_GAIN_MSB:`LCCR_INT_GAIN_LSB]),
        .sel(gain_dec)
    );
    lccr_onehot #(.SEL_W(3)) u_time (
        .code(int_ramp_nxt[`LCCR_INT_TIME_MSB:`LCCR_INT_TIME_LSB]),
        .sel(time_dec)
    );
    lccr_onehot #(.SEL_W(3)) u_ramp (
        .code(int_ramp_nxt[`LCCR_RAMP_MSB:`LCCR_RAMP_LSB]),
        .sel(ramp_dec)
    );

    // -------------------------------------------------------------------
    // Registers and loop outputs
    // -------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            int_ramp_r <= `LCCR_INT_RAMP_RST;
            alt_ac_r <= `LCCR_ALT_AC_RST;
            load_pend_r <= 1'b1;
            cfg_loaded <= 1'b0;
            int_gain_sel <= 4'h0;
            int_time_sel <= 8'h00;
            ramp_sel <= 8'h00;
        end else begin
            int_ramp_r <= int_ramp_nxt;
            alt_ac_r <= alt_ac_nxt;
            if (do_load) begin
                load_pend_r <= 1'b0;
                cfg_loaded <= 1'b1;
            end
            // Selects follow the register at the same edge
            int_gain_sel <= gain_dec;
            int_time_sel <= time_dec;
            ramp_sel <= ramp_dec;
        end
    end

    // -------------------------------------------------------------------
    // Command answer: ack for a known code, read byte returned
    // -------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            rsp_valid <= cmd_valid;
            rsp_ack <= cmd_valid & (hit_int | hit_alt);
            rsp_rdata <= 8'h00;
            if (cmd_valid && !cmd_write && hit_int) begin
                rsp_rdata <= int_ramp_r;
            end
            if (cmd_valid && !cmd_write && hit_alt) begin
                rsp_rdata <= alt_ac_r;
            end
        end
    end

endmodule

//--- lccr_asserts.sv
`timescale 1ns/1ps
module lccr_asserts (
    input wire core_clk, rst, nvm_valid, cmd_valid, cmd_write,
    input wire [7:0] nvm_int_ramp, nvm_alt_ac, cmd_code, cmd_wdata,
    input wire rsp_valid, rsp_ack, cfg_loaded,
    input wire [7:0] rsp_rdata, int_time_sel, ramp_sel,
    input wire [3:0] int_gain_sel
);
    reg [7:0] wd_r;
    wire mapped = cmd_code == 8'haa || cmd_code == 8'hab;
    wire aa_wr = cmd_valid && cmd_write && cmd_code == 8'haa;
    always @(posedge core_clk) wd_r <= cmd_wdata;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_rsp_next: assert property (cmd_valid |=> rsp_valid)
        else $error("no response");
    chk_rsp_idle: assert property (!cmd_valid |=> !rsp_valid)
        else $error("stray response");
    chk_ack_map: assert property (cmd_valid && mapped |=> rsp_ack)
        else $error("mapped code not acked");
    chk_unmap_nak: assert property (cmd_valid && !mapped
        |=> !rsp_ack && rsp_rdata == 8'h00) else $error("unmapped acked");
    chk_gain_wr: assert property (aa_wr
        |=> int_gain_sel == 4'h1 << wd_r[7:6]) else $error("gain select");
    chk_time_wr: assert property (aa_wr
        |=> int_time_sel == 8'h1 << wd_r[5:3]) else $error("time select");
    chk_ramp_wr: assert property (aa_wr
        |=> ramp_sel == 8'h1 << wd_r[2:0]) else $error("ramp select");
    chk_sel_hold: assert property (cfg_loaded && !aa_wr
        |=> $stable(int_gain_sel) && $stable(int_time_sel)
        && $stable(ramp_sel)) else $error("select moved");
    chk_load_keep: assert property (cfg_loaded |=> cfg_loaded)
        else $error("load flag dropped");
    cover property (aa_wr);
    cover property (cmd_valid && !cmd_write && mapped);
    cover property ($rose(cfg_loaded));
endmodule
bind lccr_top lccr_asserts u_chk (.*);

//--- lccr_host.sv
`timescale 1ns/1ps
module lccr_host (
    input wire core_clk,
    output reg cmd_valid = 0,
    output reg cmd_write = 0,
    output reg [7:0] cmd_code = 0,
    output reg [7:0] cmd_wdata = 0
);
    task xfer(input w, input [7:0] c, input [7:0] d);
        @(posedge core_clk);
        cmd_valid <= 1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge core_clk);
        cmd_valid <= 0;
        // Idle lines show the inverted last code and byte, not the last ones
        cmd_code <= ~c;
        cmd_wdata <= ~d;
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg core_clk = 0, rst = 1, nvm_valid = 0;
    reg [7:0] nvm_int_ramp = 8'h9b, nvm_alt_ac = 8'h71, last_r = 8'h9b;
    wire cmd_valid, cmd_write, rsp_valid, rsp_ack, cfg_loaded;
    wire [7:0] cmd_code, cmd_wdata, rsp_rdata, int_time_sel, ramp_sel;
    wire [3:0] int_gain_sel;
    integer miscompares = 0, checked = 0, cycles = 0, i;
    // Legal rows only: alternate gain codes stay at or below 1011b
    reg [15:0] rows [0:4] = '{16'haa5a, 16'haaff, 16'habbf, 16'haa24,
        16'hab00};
    always #4 core_clk = ~core_clk;
    lccr_host host (.*);
    lccr_top uut (.*);
    task chk(input [7:0] g, input [7:0] e);
        checked = checked + 1;
        if (g !== e) begin
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
            miscompares = miscompares + 1;
        end
    endtask
    task op(input w, input [7:0] c, input [7:0] d);
        host.xfer(w, c, d);
        #1;
        chk({7'h0, rsp_valid}, 8'h01);
        chk({7'h0, rsp_ack}, {7'h0, c == 8'haa || c == 8'hab});
    endtask
    task sel_chk(input [7:0] v);
        chk({4'h0, int_gain_sel}, 8'h1 << v[7:6]);
        chk(int_time_sel, 8'h1 << v[5:3]);
        chk(ramp_sel, 8'h1 << v[2:0]);
    endtask
    task complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 0;
        #1;
        chk({4'h0, int_gain_sel} | int_time_sel | ramp_sel, 8'h00);
        @(posedge core_clk) nvm_valid <= 1;
        @(posedge core_clk) nvm_int_ramp <= 8'h00;
        #1;
        chk({7'h0, cfg_loaded}, 8'h01);
        sel_chk(8'h9b);
        op(0, 8'haa, 8'h00);
        chk(rsp_rdata, 8'h9b);
        @(posedge core_clk) nvm_valid <= 0;
        op(0, 8'hab, 8'h00);
        chk(rsp_rdata, 8'h71);
        for (i = 0; i < 5; i = i + 1) begin
            op(1, rows[i][15:8], rows[i][7:0]);
            if (rows[i][15:8] == 8'haa) last_r = rows[i][7:0];
            sel_chk(last_r);
            op(0, rows[i][15:8], 8'h00);
            chk(rsp_rdata, rows[i][7:0]);
        end
        op(1, 8'hac, 8'h55);
        op(0, 8'hac, 8'h00);
        chk(rsp_rdata, 8'h00);
        op(0, 8'haa, 8'h00);
        chk(rsp_rdata, 8'h24);
        @(posedge core_clk) rst <= 1;
        @(posedge core_clk) rst <= 0;
        #1;
        chk({4'h0, int_gain_sel} | ramp_sel | {7'h0, cfg_loaded}, 8'h00);
        chk(int_time_sel | {7'h0, rsp_valid}, 8'h00);
        @(posedge core_clk) nvm_valid <= 1;
        @(posedge core_clk) nvm_valid <= 0;
        #1;
        chk({7'h0, cfg_loaded}, 8'h01);
        sel_chk(8'h00);
        op(0, 8'hab, 8'h00);
        chk(rsp_rdata, 8'h71);
        complete_run;
    end
endmodule
